// *** core/tac_thermal.sv ***
// thermal alarm, temperature code and sensed current compensation with ahb-lite registers
`timescale 1ns/100ps
`include "tac_regs.svh"

// Function
// - hot alarm is open drain and only meaningful after enable
// - at 100 degrees assert below 39.12 %, release when both above 40.98 %
// - assert and release ratios follow the max temperature setting, 90 to 120
// - primary divider ratio becomes a 6-bit code linear in temperature
// - offset plus temperature code give a gain applied to each channel current
// - compensated current, not raw, feeds droop and overcurrent
// - per-output offset setting: twelve steps 13 to 43.2 degrees, plus off
// - off code passes sensed current unchanged
// - strap parameters captured before soft-start, cleared on disable or reset
module tac_thermal #(
    parameter int NUM_PH = 4,
    parameter int CUR_W = 12
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // divider ratios in 0.01 % of supply and offset straps, asynchronous pins
    input wire logic [13:0] primary_thermistor_input,
    input wire logic [13:0] secondary_thermistor_input,
    input wire logic [3:0] primary_comp_temp_offset,
    input wire logic [3:0] secondary_comp_temp_offset,
    // open-drain hot alarm toward the processor hot input
    input wire logic regulator_hot_alarm_n_in,
    output logic regulator_hot_alarm_n_out,
    output logic regulator_hot_alarm_n_oe,
    // sensed channel currents, same clock
    input wire logic [NUM_PH*CUR_W-1:0] multiphase_sense_current,
    input wire logic [CUR_W-1:0] single_phase_sense_current,
    // compensated currents for droop and overcurrent
    output logic [NUM_PH*CUR_W-1:0] multiphase_comp_current,
    output logic [CUR_W-1:0] single_phase_comp_current,
    // sequencing and interrupt
    output logic params_ready,
    output logic irq
);

    // assert and release ratios per setting; slot 7 repeats the top step since stores clamp
    localparam logic [13:0] ASSERT_TBL [8] = '{`TAC_ASSERT_90, `TAC_ASSERT_95, `TAC_ASSERT_100,
        `TAC_ASSERT_105, `TAC_ASSERT_110, `TAC_ASSERT_115, `TAC_ASSERT_120, `TAC_ASSERT_120};
    localparam logic [13:0] RELEASE_TBL [8] = '{`TAC_RELEASE_90, `TAC_RELEASE_95,
        `TAC_RELEASE_100, `TAC_RELEASE_105, `TAC_RELEASE_110, `TAC_RELEASE_115,
        `TAC_RELEASE_120, `TAC_RELEASE_120};

    // divider ratio every 16 degrees, a lower ratio being hotter
    localparam logic [13:0] KNOT_TBL [9] = '{`TAC_KNOT0, `TAC_KNOT1, `TAC_KNOT2, `TAC_KNOT3,
        `TAC_KNOT4, `TAC_KNOT5, `TAC_KNOT6, `TAC_KNOT7, `TAC_KNOT8};

    // offset codes in tenths of a degree; codes beyond the table mean off
    localparam logic [11:0] TC_TBL [12] = '{`TAC_TC0, `TAC_TC1, `TAC_TC2, `TAC_TC3, `TAC_TC4,
        `TAC_TC5, `TAC_TC6, `TAC_TC7, `TAC_TC8, `TAC_TC9, `TAC_TC10, `TAC_TC11};

    // ratio at which the code reaches c (2 degrees per step), interpolated
    function automatic logic [13:0] code_thr(input int c);
        int a;
        int b;
        a = int'(KNOT_TBL[c / 8]);
        b = int'(KNOT_TBL[c / 8 + 1]);
        code_thr = 14'(a - ((a - b) * (c % 8)) / 8);
    endfunction : code_thr

    // first-order dcr correction: gain falls linearly with temperature above 25 degrees
    function automatic logic [17:0] comp_gain(input logic [5:0] code, input logic [3:0] ofs);
        logic [12:0] t;
        t = 13'(code) * `TAC_TENTHS_PER_CODE
            + 13'(ofs < `TAC_OFS_COUNT ? TC_TBL[ofs] : 12'h000);
        if (ofs >= `TAC_OFS_COUNT)
            comp_gain = `TAC_GAIN_ONE;
        else if (t >= `TAC_REF_TENTHS)
            comp_gain = `TAC_GAIN_ONE - 18'(t - `TAC_REF_TENTHS) * `TAC_GAIN_SLOPE;
        else
            comp_gain = `TAC_GAIN_ONE + 18'(`TAC_REF_TENTHS - t) * `TAC_GAIN_SLOPE;
    endfunction : comp_gain

    // scale one current by a q16 gain, saturating
    function automatic logic [CUR_W-1:0] scale(input logic [CUR_W-1:0] cur,
                                               input logic [17:0] gain);
        logic [CUR_W+17:0] prod;
        prod = (CUR_W + 18)'(cur) * (CUR_W + 18)'(gain);
        if (|prod[CUR_W+17:CUR_W+16])
            scale = '1;
        else
            scale = prod[CUR_W+15:16];
    endfunction : scale

    // count of set bits in the thermometer vector
    function automatic logic [5:0] ones(input logic [62:0] v);
        ones = 6'h00;
        for (int i = 0; i < 63; i++)
            ones = ones + 6'(v[i]);
    endfunction : ones

    logic [13:0] ratio_p_m_ff, ratio_p_ff, ratio_s_m_ff, ratio_s_ff;
    logic [7:0] strap_m_ff, strap_ff, dp_addr_ff;
    logic pin_m_ff, pin_ff, en_ff, hot_ff, dp_wr_ff, addr_ok, run, lo_p, lo_s, hi_both;
    tac_pkg::tac_state_e state_ff, nxt_state;
    tac_pkg::tac_cfg_s cfg_ff;
    logic [2:0] max_temperature_setting_ff;
    logic [1:0] int_stat_ff, int_mask_ff, events;
    logic [62:0] above_p, above_s;
    tac_pkg::tac_therm_s therm_p_ff, therm_s_ff;
    logic [31:0] rdata_mux;

    // two-stage synchronisers for pins; multi-bit words assumed slow against the clock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {ratio_p_m_ff, ratio_s_m_ff, strap_m_ff, pin_m_ff} <= '1;
            {ratio_p_ff, ratio_s_ff, strap_ff, pin_ff} <= '1;
        end
        else
        begin
            {ratio_p_m_ff, ratio_s_m_ff, strap_m_ff, pin_m_ff} <= {primary_thermistor_input,
                secondary_thermistor_input, primary_comp_temp_offset, secondary_comp_temp_offset,
                regulator_hot_alarm_n_in};
            {ratio_p_ff, ratio_s_ff, strap_ff, pin_ff} <= {ratio_p_m_ff, ratio_s_m_ff,
                strap_m_ff, pin_m_ff};
        end
    end

    // enable sequence: idle clears, load captures straps, run releases soft-start
    always_comb
    begin
        case (state_ff)
            tac_pkg::TAC_IDLE: nxt_state = en_ff ? tac_pkg::TAC_LOAD : tac_pkg::TAC_IDLE;
            tac_pkg::TAC_LOAD: nxt_state = en_ff ? tac_pkg::TAC_RUN : tac_pkg::TAC_IDLE;
            tac_pkg::TAC_RUN: nxt_state = en_ff ? tac_pkg::TAC_RUN : tac_pkg::TAC_IDLE;
            default: nxt_state = tac_pkg::TAC_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= tac_pkg::TAC_IDLE;
            params_ready <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            // soft-start may proceed only once parameters are held
            params_ready <= (nxt_state == tac_pkg::TAC_RUN);
        end
    end

    // strap capture; cleared while disabled so each enable reloads fresh values
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_ff <= '0;
        else if (state_ff == tac_pkg::TAC_IDLE)
            cfg_ff <= '0;
        else if (state_ff == tac_pkg::TAC_LOAD)
            cfg_ff <= strap_ff;
    end

    assign run = (state_ff == tac_pkg::TAC_RUN);

    // hysteresis comparator: either input low asserts, both high releases
    assign lo_p = ratio_p_ff < ASSERT_TBL[max_temperature_setting_ff];
    assign lo_s = ratio_s_ff < ASSERT_TBL[max_temperature_setting_ff];
    assign hi_both = (ratio_p_ff > RELEASE_TBL[max_temperature_setting_ff])
                     && (ratio_s_ff > RELEASE_TBL[max_temperature_setting_ff]);

    // alarm held released until the sequence reaches run
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hot_ff <= 1'b0;
        else if (!run)
            hot_ff <= 1'b0;
        else if (lo_p || lo_s)
            hot_ff <= 1'b1;
        else if (hi_both)
            hot_ff <= 1'b0;
    end

    // open drain: low level only; a disable drops the pull with params_ready, not a cycle later
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            regulator_hot_alarm_n_out <= 1'b0;
            regulator_hot_alarm_n_oe <= 1'b0;
        end
        else
            regulator_hot_alarm_n_oe <= en_ff && run
                && (lo_p || lo_s || (hot_ff && !hi_both));
    end

    // thermometer of code thresholds; a lower ratio means hotter
    generate
        for (genvar c = 1; c < 64; c++)
        begin : g_thr
            assign above_p[c-1] = ratio_p_ff <= code_thr(c);
            assign above_s[c-1] = ratio_s_ff <= code_thr(c);
        end
    endgenerate

    // code and gain per output, each from its own divider and offset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            therm_p_ff <= {6'h00, `TAC_GAIN_ONE};
            therm_s_ff <= {6'h00, `TAC_GAIN_ONE};
        end
        else
        begin
            therm_p_ff.code <= ones(above_p);
            therm_s_ff.code <= ones(above_s);
            therm_p_ff.gain <= comp_gain(therm_p_ff.code, cfg_ff.ofs_p);
            therm_s_ff.gain <= comp_gain(therm_s_ff.code, cfg_ff.ofs_s);
        end
    end

    // compensated currents, the only current path to droop and overcurrent
    generate
        for (genvar p = 0; p < NUM_PH; p++)
        begin : g_ph
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    multiphase_comp_current[p*CUR_W +: CUR_W] <= '0;
                else
                    multiphase_comp_current[p*CUR_W +: CUR_W] <=
                        scale(multiphase_sense_current[p*CUR_W +: CUR_W],
                              therm_p_ff.gain);
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            single_phase_comp_current <= '0;
        else
            single_phase_comp_current <= scale(single_phase_sense_current,
                                               therm_s_ff.gain);
    end

    // bus address phase: flag only valid write transfers seen while the bus is ready; the address is taken every ready cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_ff <= 1'b0;
            dp_addr_ff <= 8'h00;
        end
        else if (hready)
        begin
            dp_wr_ff <= hsel && htrans[1] && hwrite && addr_ok;
            dp_addr_ff <= haddr[7:0];
        end
    end

    // read mux in the address phase so data is ready with zero wait states
    assign addr_ok = (haddr[31:8] == 24'h00_0000);
    always_comb
    begin
        rdata_mux = 32'h0000_0000;
        if (addr_ok)
        begin
            case (haddr[7:0])
                `TAC_CTRL_OFS:
                begin
                    rdata_mux[`TAC_CTRL_EN_BIT] = en_ff;
                    rdata_mux[`TAC_CTRL_MAX_TEMPERATURE_SETTING_MSB:`TAC_CTRL_MAX_TEMPERATURE_SETTING_LSB] = max_temperature_setting_ff;
                end
                `TAC_STATUS_OFS:
                begin
                    rdata_mux[`TAC_ST_HOT_BIT] = hot_ff;
                    rdata_mux[`TAC_ST_VALID_BIT] = run;
                    rdata_mux[`TAC_ST_PIN_BIT] = pin_ff;
                    rdata_mux[`TAC_ST_CODEP_LSB +: 6] = therm_p_ff.code;
                    rdata_mux[`TAC_ST_CODES_LSB +: 6] = therm_s_ff.code;
                end
                `TAC_PARAM_OFS:
                begin
                    rdata_mux[`TAC_PAR_P_LSB +: 4] = cfg_ff.ofs_p;
                    rdata_mux[`TAC_PAR_S_LSB +: 4] = cfg_ff.ofs_s;
                end
                `TAC_INT_STAT_OFS: rdata_mux[1:0] = int_stat_ff;
                `TAC_INT_MASK_OFS: rdata_mux[1:0] = int_mask_ff;
                default: rdata_mux = 32'h0000_0000;
            endcase
        end
    end

    // bus answer: always ready and okay, so those two flops only hold their reset value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
            hrdata <= rdata_mux;
    end

    // control register: enable and max temperature setting, clamped to the top step
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_ff <= 1'(`TAC_CTRL_RST >> `TAC_CTRL_EN_BIT);
            max_temperature_setting_ff <= 3'h0;
        end
        else if (dp_wr_ff && dp_addr_ff == `TAC_CTRL_OFS)
        begin
            en_ff <= hwdata[`TAC_CTRL_EN_BIT];
            max_temperature_setting_ff <= (hwdata[`TAC_CTRL_MAX_TEMPERATURE_SETTING_MSB:`TAC_CTRL_MAX_TEMPERATURE_SETTING_LSB] > `TAC_MAX_TEMPERATURE_SETTING_TOP)
                ? `TAC_MAX_TEMPERATURE_SETTING_TOP : hwdata[`TAC_CTRL_MAX_TEMPERATURE_SETTING_MSB:`TAC_CTRL_MAX_TEMPERATURE_SETTING_LSB];
        end
    end

    // alarm edges become interrupt events; a new event beats a same-cycle clear
    assign events[`TAC_IRQ_ASSERT_BIT] = run && !hot_ff && (lo_p || lo_s);
    assign events[`TAC_IRQ_RELEASE_BIT] = run && hot_ff && !(lo_p || lo_s) && hi_both;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            int_stat_ff <= `TAC_IRQ_RST;
        else
            int_stat_ff <= (int_stat_ff & ~((dp_wr_ff && dp_addr_ff == `TAC_INT_STAT_OFS) ?
                hwdata[1:0] : 2'h0)) | events;
    end

    // mask register, and the level interrupt one cycle behind the status bits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            int_mask_ff <= `TAC_IRQ_RST;
            irq <= 1'b0;
        end
        else
        begin
            if (dp_wr_ff && dp_addr_ff == `TAC_INT_MASK_OFS)
                int_mask_ff <= hwdata[1:0];
            irq <= |(int_stat_ff & int_mask_ff);
        end
    end

endmodule : tac_thermal

// *** core/tac_regs.svh ***
// register offsets, field positions, reset values and threshold tables of the thermal block
`ifndef TAC_REGS_SVH
`define TAC_REGS_SVH

// register byte offsets on the bus
`define TAC_CTRL_OFS 8'h00
`define TAC_STATUS_OFS 8'h04
`define TAC_PARAM_OFS 8'h08
`define TAC_INT_STAT_OFS 8'h0c
`define TAC_INT_MASK_OFS 8'h10

// control fields
`define TAC_CTRL_EN_BIT 0
`define TAC_CTRL_MAX_TEMPERATURE_SETTING_LSB 4
`define TAC_CTRL_MAX_TEMPERATURE_SETTING_MSB 6
`define TAC_CTRL_RST 32'h0000_0000
`define TAC_MAX_TEMPERATURE_SETTING_TOP 3'h6

// status fields
`define TAC_ST_HOT_BIT 0
`define TAC_ST_VALID_BIT 1
`define TAC_ST_PIN_BIT 2
`define TAC_ST_CODEP_LSB 8
`define TAC_ST_CODES_LSB 16

// parameter register fields (captured offset codes)
`define TAC_PAR_P_LSB 0
`define TAC_PAR_S_LSB 4

// interrupt bits: alarm asserted, alarm released
`define TAC_IRQ_ASSERT_BIT 0
`define TAC_IRQ_RELEASE_BIT 1
`define TAC_IRQ_RST 2'h0

// alarm assert ratios in 0.01 % of supply, 90..120 degree settings
`define TAC_ASSERT_90 14'h11c8
`define TAC_ASSERT_95 14'h1082
`define TAC_ASSERT_100 14'h0f48
`define TAC_ASSERT_105 14'h0e1e
`define TAC_ASSERT_110 14'h0d04
`define TAC_ASSERT_115 14'h0bfc
`define TAC_ASSERT_120 14'h0b08
// alarm release ratios in 0.01 % of supply
`define TAC_RELEASE_90 14'h1294
`define TAC_RELEASE_95 14'h1144
`define TAC_RELEASE_100 14'h1002
`define TAC_RELEASE_105 14'h0ed0
`define TAC_RELEASE_110 14'h0dac
`define TAC_RELEASE_115 14'h0c98
`define TAC_RELEASE_120 14'h0b9a

// divider ratio at 0,16,..,128 degrees, used to linearise the temperature code
`define TAC_KNOT0 14'h252f
`define TAC_KNOT1 14'h2370
`define TAC_KNOT2 14'h20c4
`define TAC_KNOT3 14'h1d2c
`define TAC_KNOT4 14'h18ef
`define TAC_KNOT5 14'h1484
`define TAC_KNOT6 14'h105f
`define TAC_KNOT7 14'h0cd0
`define TAC_KNOT8 14'h09ec

// compensation offsets in 0.1 degree, codes 0..11; codes 12..15 are off
`define TAC_OFS_COUNT 4'hc
`define TAC_TC0 12'h082
`define TAC_TC1 12'h0a0
`define TAC_TC2 12'h0bd
`define TAC_TC3 12'h0d8
`define TAC_TC4 12'h0f3
`define TAC_TC5 12'h10e
`define TAC_TC6 12'h129
`define TAC_TC7 12'h144
`define TAC_TC8 12'h15f
`define TAC_TC9 12'h17a
`define TAC_TC10 12'h195
`define TAC_TC11 12'h1b0

// gain arithmetic: unity in q16, reference 25.0 degrees, q16 drop per 0.1 degree
`define TAC_GAIN_ONE 18'h1_0000
`define TAC_REF_TENTHS 13'h00fa
`define TAC_GAIN_SLOPE 18'h0_0019
`define TAC_TENTHS_PER_CODE 13'h0014

`endif

// *** core/tac_pkg.sv ***
// types shared by the thermal alarm and current compensation block
package tac_pkg;

    // enable and capture sequence, one bit flips per step from idle to run, two back to idle
    typedef enum logic [1:0] {
        TAC_IDLE = 2'h0,
        TAC_LOAD = 2'h1,
        TAC_RUN = 2'h3
    } tac_state_e;

    // parameters captured before soft-start
    typedef struct packed {
        logic [3:0] ofs_p;
        logic [3:0] ofs_s;
    } tac_cfg_s;

    // one output's thermal view
    typedef struct packed {
        logic [5:0] code;
        logic [17:0] gain;
    } tac_therm_s;

endpackage : tac_pkg

// *** test/tac_sva.sv ***
// concurrent checks on the ports of the thermal alarm block
`timescale 1ns/100ps
`include "tac_regs.svh"
module tac_sva #(
    parameter int NUM_PH = 4,
    parameter int CUR_W = 12
) (
    // clock, reset and bus response
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    // divider ratios and straps
    input wire logic [13:0] primary_thermistor_input,
    input wire logic [13:0] secondary_thermistor_input,
    input wire logic [3:0] primary_comp_temp_offset,
    input wire logic [3:0] secondary_comp_temp_offset,
    // alarm pin
    input wire logic regulator_hot_alarm_n_out,
    input wire logic regulator_hot_alarm_n_oe,
    // currents and sequencing
    input wire logic [NUM_PH*CUR_W-1:0] multiphase_sense_current,
    input wire logic [CUR_W-1:0] single_phase_sense_current,
    input wire logic [NUM_PH*CUR_W-1:0] multiphase_comp_current,
    input wire logic [CUR_W-1:0] single_phase_comp_current,
    input wire logic params_ready,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic cold;
    logic hot;
    logic [2:0] cold_ff;
    logic [2:0] hot_ff;
    // beyond every setting's thresholds, so true whatever the setting
    assign cold = primary_thermistor_input > `TAC_RELEASE_90
        && secondary_thermistor_input > `TAC_RELEASE_90;
    assign hot = primary_thermistor_input < `TAC_ASSERT_120
        || secondary_thermistor_input < `TAC_ASSERT_120;
    // saturating run lengths; the sync chain needs three edges to settle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cold_ff <= 3'h0;
            hot_ff <= 3'h0;
        end
        else
        begin
            cold_ff <= !cold ? 3'h0 : cold_ff + {2'h0, cold_ff != 3'h7};
            hot_ff <= !hot ? 3'h0 : hot_ff + {2'h0, hot_ff != 3'h7};
        end
    end
    a_pin_sinks_only: assert property (regulator_hot_alarm_n_out == 1'b0)
        else $error("alarm pin driven high");
    a_idle_released: assert property (!params_ready |-> !regulator_hot_alarm_n_oe)
        else $error("alarm pulled while not running");
    a_cold_release: assert property (cold_ff >= 3'h4 |-> !regulator_hot_alarm_n_oe)
        else $error("alarm held with both inputs cool");
    a_hot_pull: assert property (hot_ff >= 3'h4 && params_ready && $past(params_ready, 4)
        |-> regulator_hot_alarm_n_oe)
        else $error("alarm not pulled with an input hot");
    a_mp_bypass: assert property (params_ready && $past(params_ready, 4)
        && primary_comp_temp_offset >= 4'hc && $past(primary_comp_temp_offset, 4) >= 4'hc
        |-> multiphase_comp_current == $past(multiphase_sense_current))
        else $error("multiphase current altered with compensation off");
    a_sp_bypass: assert property (params_ready && $past(params_ready, 4)
        && secondary_comp_temp_offset >= 4'hc
        |-> single_phase_comp_current == $past(single_phase_sense_current))
        else $error("single phase current altered with compensation off");
    a_bus_ready: assert property (hreadyout)
        else $error("wait state inserted");
    a_bus_okay: assert property (!hresp)
        else $error("error response");
    c_alarm: cover property ($rose(regulator_hot_alarm_n_oe));
    c_irq: cover property ($rose(irq));
    c_run: cover property ($rose(params_ready));
endmodule : tac_sva

bind tac_thermal tac_sva #(.NUM_PH(NUM_PH), .CUR_W(CUR_W)) i_tac_sva (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .primary_thermistor_input(primary_thermistor_input),
    .secondary_thermistor_input(secondary_thermistor_input),
    .primary_comp_temp_offset(primary_comp_temp_offset),
    .secondary_comp_temp_offset(secondary_comp_temp_offset),
    .regulator_hot_alarm_n_out(regulator_hot_alarm_n_out),
    .regulator_hot_alarm_n_oe(regulator_hot_alarm_n_oe),
    .multiphase_sense_current(multiphase_sense_current),
    .single_phase_sense_current(single_phase_sense_current),
    .multiphase_comp_current(multiphase_comp_current),
    .single_phase_comp_current(single_phase_comp_current),
    .params_ready(params_ready), .irq(irq));

// *** test/tac_partner.sv ***
// thermistor dividers and the pulled-up hot line
`timescale 1ns/100ps
module tac_partner #(
    parameter int LAG = 0
) (
    // clock and requested divider ratios
    input wire logic hclk,
    input wire logic [13:0] p_req,
    input wire logic [13:0] s_req,
    // controller drive and what the pins show
    input wire logic alarm_out,
    input wire logic alarm_oe,
    output logic [13:0] p_ratio,
    output logic [13:0] s_ratio,
    output logic hot_line
);
    logic [13:0] p_ff;
    logic [13:0] s_ff;
    // a decoupled divider settles a cycle late
    always_ff @(posedge hclk)
    begin
        p_ff <= p_req;
        s_ff <= s_req;
    end
    assign p_ratio = (LAG != 0) ? p_ff : p_req;
    assign s_ratio = (LAG != 0) ? s_ff : s_req;
    // pull-up wins unless the controller sinks the line
    assign hot_line = (alarm_oe && !alarm_out) ? 1'b0 : 1'b1;
endmodule : tac_partner

// *** test/test_tac_thermal.sv ***
// self-checking bench for the thermal alarm and current compensation block
`timescale 1ns/100ps
`include "tac_regs.svh"
`define CK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end
module test_tac_thermal;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [13:0] p_req = 14'h1770;
    logic [13:0] s_req = 14'h1770;
    logic [3:0] ofs_p = 4'h0;
    logic [47:0] mp_raw = {4{12'h3e8}};
    logic [11:0] sp_raw = 12'h3e8;
    logic hready, hresp, irq, rdy, a_out, a_oe, line;
    logic [31:0] hrdata, q;
    logic [13:0] p_rat, s_rat, v;
    logic [47:0] mp_cmp;
    logic [11:0] sp_cmp;
    logic [13:0] at_t[7] = '{14'h11c8, 14'h1082, 14'h0f48, 14'h0e1e, 14'h0d04, 14'h0bfc,
        14'h0b08};
    logic [13:0] rl_t[7] = '{14'h1294, 14'h1144, 14'h1002, 14'h0ed0, 14'h0dac, 14'h0c98,
        14'h0b9a};
    int tc_t[12] = '{130, 160, 189, 216, 243, 270, 297, 324, 351, 378, 405, 432};
    int n_fail = 0;
    int samples_checked = 0;
    int e;

    // 25 MHz bus clock
    initial forever #20 hclk = ~hclk;

    tac_thermal i_tac_thermal (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .primary_thermistor_input(p_rat), .secondary_thermistor_input(s_rat),
        .primary_comp_temp_offset(ofs_p), .secondary_comp_temp_offset(4'hc),
        .regulator_hot_alarm_n_in(line), .regulator_hot_alarm_n_out(a_out),
        .regulator_hot_alarm_n_oe(a_oe), .multiphase_sense_current(mp_raw),
        .single_phase_sense_current(sp_raw), .multiphase_comp_current(mp_cmp),
        .single_phase_comp_current(sp_cmp), .params_ready(rdy), .irq(irq));

    tac_partner #(.LAG(1)) i_tac_partner (.hclk(hclk), .p_req(p_req), .s_req(s_req),
        .alarm_out(a_out), .alarm_oe(a_oe), .p_ratio(p_rat), .s_ratio(s_rat),
        .hot_line(line));

    task tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : tick

    // one single transfer; waits on hready, read data taken at the closing edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        `CK("reg", x, q & m)
    endtask : rc

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // watchdog, far beyond the few hundred cycles the tests take
    initial
    begin
        #800000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        // reset values, read-only and unmapped places
        rc(`TAC_CTRL_OFS, 32'hffff_ffff, 32'h0000_0000);
        rc(`TAC_INT_MASK_OFS, 32'hffff_ffff, 32'h0000_0000);
        rc(`TAC_STATUS_OFS, 32'h0000_0007, 32'h0000_0004);
        wr(`TAC_PARAM_OFS, 32'h0000_00ff);
        wr(8'h20, 32'hffff_ffff);
        rc(`TAC_PARAM_OFS, 32'hffff_ffff, 32'h0000_0000);
        rc(8'h20, 32'hffff_ffff, 32'h0000_0000);
        // every offset code then off, at code 40 (80 degrees)
        p_req <= 14'h1484;
        for (int i = 0; i < 13; i++)
        begin
            wr(`TAC_CTRL_OFS, 32'h0000_0000);
            ofs_p <= (i < 12) ? i[3:0] : 4'hf;
            tick(2);
            `CK("ready", 1'b0, rdy)
            wr(`TAC_CTRL_OFS, 32'h0000_0001);
            for (int k = 0; k < 20 && rdy !== 1'b1; k++) tick(1);
            tick(6);
            rc(`TAC_PARAM_OFS, 32'h0000_00ff, {24'h0, 4'hc, ofs_p});
            rc(`TAC_STATUS_OFS, 32'h003f_3f00, {10'h0, 6'h22, 2'h0, 6'h28, 8'h0});
            e = (i < 12) ? (1000 * (65536 - 25 * (550 + tc_t[i]))) >> 16 : 1000;
            `CK("mp", {4{e[11:0]}}, mp_cmp)
            `CK("sp", sp_raw, sp_cmp)
        end
        // each setting: strict assert, hold band, strict release, either input
        for (int s = 0; s < 7; s++)
        begin
            wr(`TAC_INT_MASK_OFS, (s == 0) ? 32'h0000_0000 : 32'h0000_0003);
            wr(`TAC_CTRL_OFS, {25'h0, s[2:0], 4'h1});
            for (int k = 0; k < 4; k++)
            begin
                v = (k < 2) ? at_t[s] - 14'(k) : rl_t[s] + 14'(k - 2);
                if (s[0])
                    s_req <= v;
                else
                    p_req <= v;
                tick(6);
                `CK("hot", k == 1 || k == 2, a_oe)
                if (k == 1)
                begin
                    `CK("irq", s != 0, irq)
                    rc(`TAC_STATUS_OFS, 32'h0000_0007, 32'h0000_0003);
                end
            end
            rc(`TAC_INT_STAT_OFS, 32'h0000_0003, 32'h0000_0003);
            wr(`TAC_INT_STAT_OFS, 32'h0000_0003);
            tick(2);
            `CK("irq", 1'b0, irq)
            rc(`TAC_INT_STAT_OFS, 32'hffff_ffff, 32'h0000_0000);
        end
        wr(`TAC_CTRL_OFS, 32'h0000_0071);
        rc(`TAC_CTRL_OFS, 32'h0000_0071, 32'h0000_0061);
        // disable while hot releases the line and drops params_ready
        p_req <= 14'h07d0;
        tick(6);
        `CK("hot", 1'b1, a_oe)
        wr(`TAC_CTRL_OFS, 32'h0000_0000);
        tick(1);
        `CK("hot", 1'b0, a_oe)
        `CK("ready", 1'b0, rdy)
        report_and_stop();
    end
endmodule : test_tac_thermal
